// >>> core/lfr_pkg.sv
// constants and carriers for the lf receiver register slice
// assumes an 8-bit register port and one 200 MHz core clock
package lfr_pkg;

  // ***************************************************************
  // register map (index on the address port)
  // ***************************************************************
  localparam logic [2:0] ADDR_STATUS = 3'h0;
  localparam logic [2:0] ADDR_DATA_CTLD = 3'h1;
  localparam logic [2:0] ADDR_IDH_CTLE = 3'h2;
  localparam logic [2:0] ADDR_IDL = 3'h3;
  localparam logic [2:0] ADDR_CONFIG = 3'h5;

  // ***************************************************************
  // field positions
  // ***************************************************************
  localparam int ST_READY_BIT = 7;
  localparam int ST_OVERRUN_BIT = 3;
  localparam int ST_ACK_BIT = 0;
  localparam int CFG_PAGE_BIT = 7;
  localparam int CFG_IRQEN_BIT = 6;
  localparam int CFG_ID_CHECK_SELECT_LSB = 4;
  localparam int CFG_EDGE_LSB = 0;
  localparam int CD_DELAY_LSB = 6;
  localparam int CD_DAMP_BIT = 5;
  localparam int CD_TRIG_LSB = 3;
  localparam int CD_ON_TIME_ERROR_MODE_BIT = 2;
  localparam int CD_CARRIER_LSB = 0;

  // ***************************************************************
  // reset values and encodings
  // ***************************************************************
  localparam logic [2:0] EDGE_CNT_RST = 3'h6;
  localparam logic [3:0] LFSR_RST = 4'h1;
  localparam logic [1:0] ID_OFF = 2'h0;
  localparam logic [1:0] ID_HIGH = 2'h1;
  localparam logic [1:0] ID_LOW = 2'h2;
  localparam logic [1:0] ID_BOTH = 2'h3;
  localparam logic [1:0] TRIG_COUNT = 2'h0;
  localparam logic [1:0] TRIG_RANDOM = 2'h1;
  localparam logic [1:0] TRIG_LOW = 2'h2;
  localparam logic [1:0] TRIG_HIGH = 2'h3;
  localparam logic [1:0] DLY_HALF = 2'h2;
  localparam logic [1:0] DLY_ONE_HALF = 2'h3;
  localparam logic [1:0] CARRIER_SAME = 2'h3;
  localparam logic [1:0] CARRIER_LONG = 2'h0;

  // ***************************************************************
  // timing
  // ***************************************************************
  localparam int CLK_PERIOD_PS = 5000;
  localparam int AZ_HALF_PERIOD_PS = 4000000;
  localparam int AZ_HALF_CYC = AZ_HALF_PERIOD_PS / CLK_PERIOD_PS;
  localparam int SYNC_W = 3;

  // ***************************************************************
  // carriers
  // ***************************************************************
  typedef struct packed {
    logic [2:0] addr;
    logic [7:0] wdata;
    logic wr;
    logic rd;
  } lfr_bus_req_t;

  typedef struct packed {
    logic [SYNC_W-1:0] stage1;
    logic [SYNC_W-1:0] stage2;
  } lfr_sync_t;

  typedef enum logic [1:0] {RX_IDLE, RX_ID, RX_DATA, RX_IGNORE} lfr_rx_state_t;

  typedef struct packed {
    lfr_rx_state_t rxState;
    logic [7:0] shiftReg;
    logic [2:0] bitCnt;
    logic idPhase;
    logic [7:0] rxByte;
    logic byteReady;
    logic overrun;
    logic [7:0] idHigh;
    logic [7:0] idLow;
    logic [2:0] azSeqCtl;
    logic [1:0] releaseDelay;
    logic [1:0] trigMode;
    logic on_time_error_mode;
    logic [1:0] carrierMethod;
    logic pageSel;
    logic irqEnable;
    logic [1:0] idSelect;
    logic [2:0] edgeCount;
    logic [7:0] rdData;
    logic irq;
    logic sumPrev;
    logic [11:0] relCnt;
    logic azCtrl;
    logic dataPrev;
    logic [3:0] edgeSeen;
    logic [3:0] azTarget;
    logic [3:0] lfsr;
    logic azRequest;
    logic onTimeEnd;
    logic sniffReturn;
    logic wakeMcu;
  } lfr_state_t;

endpackage : lfr_pkg

// >>> core/lfr_regs.sv
// lf receiver data, identifier and control register slice
// assumes the demodulator delivers bits and message framing on core_clk;
// damping status, demodulated level and summing enable are asynchronous
// Notes on behaviour
// - complete bytes copied to data register, ready set
// - new byte while unread also sets overrun
// - data register ignores writes entirely
// - reading data register clears byte ready
// - data and identifier registers only on page zero
// - sixteen-bit identifier, two bytes, reset to zero
// - mismatching identifier ignores message, mcu stays asleep
// - control d register only on page one
// - sequencer low bits choose auto-zero sequence
// - sequencer bit two shifts sensitivity trim
// - delay auto-zero release after summing enable falls
// - control d bit five shows damping activity
// - trigger field selects auto-zero start condition
// - on-time error mode chooses end or sniff
// - carrier check field selects validation packets
// - acknowledge write clears ready and overrun flags
// - interrupt when ready flag and enable set
module lfr_regs
#(
  parameter int REL_HALF_CYC = lfr_pkg::AZ_HALF_CYC
)
(
  // clock and reset
  input wire logic core_clk,
  input wire logic rst,
  // register port
  input wire lfr_pkg::lfr_bus_req_t busReq,
  output logic [7:0] busRdata,
  // demodulator
  input wire logic msgActive,
  input wire logic rxBitValid,
  input wire logic rxBit,
  input wire logic rxError,
  // analog levels
  input wire logic dampingActive,
  input wire logic demodData,
  input wire logic sumAzEn,
  // analog controls
  output logic [1:0] azSequence,
  output logic trimShift,
  output logic azCtrl,
  output logic azRequest,
  output logic [1:0] carrierMethod,
  // system
  output logic irq,
  output logic wakeMcu,
  output logic onTimeEnd,
  output logic sniffReturn
);

  if (REL_HALF_CYC < 1 || 3 * REL_HALF_CYC > 4095)
  begin : g_bad_param
    $error("REL_HALF_CYC out of range");
  end

  localparam logic [11:0] REL_HALF = REL_HALF_CYC[11:0];
  localparam logic [11:0] REL_ONE_HALF = 12'(3 * REL_HALF_CYC);

  lfr_pkg::lfr_state_t st;
  lfr_pkg::lfr_state_t next_st;
  logic [lfr_pkg::SYNC_W-1:0] syncLvl;
  logic dampSync;
  logic dataSync;
  logic sumSync;
  logic byteDone;
  logic [7:0] doneByte;
  logic [3:0] newTarget;
  logic page0;
  logic page1;

  // ***************************************************************
  // input synchronisers
  // ***************************************************************
  lfr_sync u_sync
  (
    .core_clk(core_clk),
    .rst(rst),
    .asyncIn({sumAzEn, demodData, dampingActive}),
    .syncOut(syncLvl)
  );

  assign dampSync = syncLvl[0];
  assign dataSync = syncLvl[1];
  assign sumSync = syncLvl[2];
  assign page0 = !st.pageSel;
  assign page1 = st.pageSel;

  // ***************************************************************
  // next state
  // ***************************************************************
  always_comb
  begin
    next_st = st;
    next_st.rdData = 8'h00;
    next_st.azRequest = 1'b0;
    next_st.onTimeEnd = 1'b0;
    next_st.sniffReturn = 1'b0;
    next_st.wakeMcu = 1'b0;
    byteDone = 1'b0;
    doneByte = {st.shiftReg[6:0], rxBit};
    newTarget = 4'h0;

    // byte assembly and identifier filter
    case (st.rxState)
      lfr_pkg::RX_IDLE:
      begin
        if (msgActive)
        begin
          next_st.bitCnt = 3'h0;
          next_st.idPhase = 1'b0;
          next_st.rxState = (st.idSelect == lfr_pkg::ID_OFF) ?
                            lfr_pkg::RX_DATA : lfr_pkg::RX_ID;
        end
      end
      lfr_pkg::RX_ID:
      begin
        if (!msgActive)
        begin
          next_st.rxState = lfr_pkg::RX_IDLE;
        end
        else if (rxBitValid)
        begin
          next_st.shiftReg = doneByte;
          next_st.bitCnt = st.bitCnt + 3'h1;
          if (st.bitCnt == 3'h7)
          begin
            if (st.idPhase)
            begin
              next_st.rxState = (doneByte == st.idLow) ?
                                lfr_pkg::RX_DATA : lfr_pkg::RX_IGNORE;
            end
            else if (st.idSelect == lfr_pkg::ID_LOW)
            begin
              next_st.rxState = (doneByte == st.idLow) ?
                                lfr_pkg::RX_DATA : lfr_pkg::RX_IGNORE;
            end
            else if (doneByte != st.idHigh)
            begin
              next_st.rxState = lfr_pkg::RX_IGNORE;
            end
            else if (st.idSelect == lfr_pkg::ID_BOTH)
            begin
              next_st.idPhase = 1'b1;
            end
            else
            begin
              next_st.rxState = lfr_pkg::RX_DATA;
            end
            next_st.wakeMcu = (next_st.rxState == lfr_pkg::RX_DATA);
          end
        end
      end
      lfr_pkg::RX_DATA:
      begin
        if (!msgActive)
        begin
          next_st.rxState = lfr_pkg::RX_IDLE;
        end
        else if (rxBitValid)
        begin
          next_st.shiftReg = doneByte;
          next_st.bitCnt = st.bitCnt + 3'h1;
          byteDone = (st.bitCnt == 3'h7);
        end
      end
      lfr_pkg::RX_IGNORE:
      begin
        if (!msgActive)
        begin
          next_st.rxState = lfr_pkg::RX_IDLE;
        end
      end
      default:
      begin
        next_st.rxState = lfr_pkg::RX_IDLE;
      end
    endcase

    // flag clears first so that a completing byte wins
    if (busReq.wr && page0 && busReq.addr == lfr_pkg::ADDR_STATUS &&
        busReq.wdata[lfr_pkg::ST_ACK_BIT])
    begin
      next_st.byteReady = 1'b0;
      next_st.overrun = 1'b0;
    end
    if (busReq.rd && page0 && busReq.addr == lfr_pkg::ADDR_DATA_CTLD)
    begin
      next_st.byteReady = 1'b0;
    end
    if (byteDone)
    begin
      next_st.rxByte = doneByte;
      next_st.byteReady = 1'b1;
      if (st.byteReady)
      begin
        next_st.overrun = 1'b1;
      end
    end

    // register writes; the data register has no write path
    if (busReq.wr)
    begin
      case (busReq.addr)
        lfr_pkg::ADDR_DATA_CTLD:
        begin
          if (page1)
          begin
            next_st.releaseDelay = busReq.wdata[lfr_pkg::CD_DELAY_LSB +: 2];
            next_st.trigMode = busReq.wdata[lfr_pkg::CD_TRIG_LSB +: 2];
            next_st.on_time_error_mode = busReq.wdata[lfr_pkg::CD_ON_TIME_ERROR_MODE_BIT];
            next_st.carrierMethod = busReq.wdata[lfr_pkg::CD_CARRIER_LSB +: 2];
          end
        end
        lfr_pkg::ADDR_IDH_CTLE:
        begin
          if (page0)
          begin
            next_st.idHigh = busReq.wdata;
          end
          else
          begin
            next_st.azSeqCtl = busReq.wdata[2:0];
          end
        end
        lfr_pkg::ADDR_IDL:
        begin
          if (page0)
          begin
            next_st.idLow = busReq.wdata;
          end
        end
        lfr_pkg::ADDR_CONFIG:
        begin
          next_st.pageSel = busReq.wdata[lfr_pkg::CFG_PAGE_BIT];
          next_st.irqEnable = busReq.wdata[lfr_pkg::CFG_IRQEN_BIT];
          next_st.idSelect = busReq.wdata[lfr_pkg::CFG_ID_CHECK_SELECT_LSB +: 2];
          next_st.edgeCount = busReq.wdata[lfr_pkg::CFG_EDGE_LSB +: 3];
        end
        default:
        begin
        end
      endcase
    end

    // register reads, data one cycle later
    if (busReq.rd)
    begin
      case (busReq.addr)
        lfr_pkg::ADDR_STATUS:
        begin
          if (page0)
          begin
            next_st.rdData[lfr_pkg::ST_READY_BIT] = st.byteReady;
            next_st.rdData[lfr_pkg::ST_OVERRUN_BIT] = st.overrun;
          end
        end
        lfr_pkg::ADDR_DATA_CTLD:
        begin
          if (page0)
          begin
            next_st.rdData = st.rxByte;
          end
          else
          begin
            next_st.rdData[lfr_pkg::CD_DELAY_LSB +: 2] = st.releaseDelay;
            next_st.rdData[lfr_pkg::CD_DAMP_BIT] = dampSync;
            next_st.rdData[lfr_pkg::CD_TRIG_LSB +: 2] = st.trigMode;
            next_st.rdData[lfr_pkg::CD_ON_TIME_ERROR_MODE_BIT] = st.on_time_error_mode;
            next_st.rdData[lfr_pkg::CD_CARRIER_LSB +: 2] = st.carrierMethod;
          end
        end
        lfr_pkg::ADDR_IDH_CTLE:
        begin
          next_st.rdData = page0 ? st.idHigh : {5'h00, st.azSeqCtl};
        end
        lfr_pkg::ADDR_IDL:
        begin
          next_st.rdData = page0 ? st.idLow : 8'h00;
        end
        lfr_pkg::ADDR_CONFIG:
        begin
          next_st.rdData[lfr_pkg::CFG_PAGE_BIT] = st.pageSel;
          next_st.rdData[lfr_pkg::CFG_IRQEN_BIT] = st.irqEnable;
          next_st.rdData[lfr_pkg::CFG_ID_CHECK_SELECT_LSB +: 2] = st.idSelect;
          next_st.rdData[lfr_pkg::CFG_EDGE_LSB +: 3] = st.edgeCount;
        end
        default:
        begin
        end
      endcase
    end

    next_st.irq = st.byteReady && st.irqEnable;

    // auto-zero release: rise follows at once, fall may be held off
    next_st.sumPrev = sumSync;
    if (sumSync)
    begin
      next_st.azCtrl = 1'b1;
      next_st.relCnt = 12'h000;
    end
    else if (st.sumPrev)
    begin
      case (st.releaseDelay)
        lfr_pkg::DLY_HALF: next_st.relCnt = REL_HALF;
        lfr_pkg::DLY_ONE_HALF: next_st.relCnt = REL_ONE_HALF;
        default: next_st.azCtrl = 1'b0;
      endcase
    end
    else if (st.relCnt != 12'h000)
    begin
      next_st.relCnt = st.relCnt - 12'h001;
      if (st.relCnt == 12'h001)
      begin
        next_st.azCtrl = 1'b0;
      end
    end

    // auto-zero trigger on demodulated edges during data reception
    next_st.dataPrev = dataSync;
    if (st.rxState != lfr_pkg::RX_DATA)
    begin
      next_st.edgeSeen = 4'h0;
      next_st.azTarget = {1'b0, st.edgeCount};
    end
    else
    begin
      if (dataSync != st.dataPrev && st.edgeSeen != 4'hf)
      begin
        next_st.edgeSeen = st.edgeSeen + 4'h1;
      end
      if (st.edgeSeen >= st.azTarget &&
          (st.trigMode == lfr_pkg::TRIG_COUNT || st.trigMode == lfr_pkg::TRIG_RANDOM ||
           (st.trigMode == lfr_pkg::TRIG_LOW && !dataSync) ||
           (st.trigMode == lfr_pkg::TRIG_HIGH && dataSync)))
      begin
        next_st.azRequest = 1'b1;
        next_st.edgeSeen = 4'h0;
        next_st.lfsr = {st.lfsr[2:0], st.lfsr[3] ^ st.lfsr[2]};
        newTarget = {1'b0, st.edgeCount};
        if (st.trigMode == lfr_pkg::TRIG_RANDOM)
        begin
          case (st.lfsr[1:0])
            2'h0: newTarget = newTarget - 4'h1;
            2'h1: newTarget = newTarget;
            default: newTarget = newTarget + 4'h1;
          endcase
        end
        next_st.azTarget = (newTarget == 4'h0 || newTarget == 4'hf) ? 4'h1 : newTarget;
      end
    end

    // receive error behaviour
    if (rxError)
    begin
      next_st.onTimeEnd = !st.on_time_error_mode;
      next_st.sniffReturn = st.on_time_error_mode;
    end
  end

  always_ff @(posedge core_clk)
  begin
    if (rst)
    begin
      st <= '0;
      st.edgeCount <= lfr_pkg::EDGE_CNT_RST;
      st.azTarget <= {1'b0, lfr_pkg::EDGE_CNT_RST};
      st.lfsr <= lfr_pkg::LFSR_RST;
    end
    else
    begin
      st <= next_st;
    end
  end

  // ***************************************************************
  // outputs
  // ***************************************************************
  assign busRdata = st.rdData;
  assign azSequence = st.azSeqCtl[1:0];
  assign trimShift = st.azSeqCtl[2];
  assign azCtrl = st.azCtrl;
  assign azRequest = st.azRequest;
  assign carrierMethod = st.carrierMethod;
  assign irq = st.irq;
  assign wakeMcu = st.wakeMcu;
  assign onTimeEnd = st.onTimeEnd;
  assign sniffReturn = st.sniffReturn;

  // ***************************************************************
  // assertions
  // ***************************************************************
  property p_ready_set;
    @(posedge core_clk) disable iff (rst) byteDone |=> st.byteReady && st.rxByte == $past(doneByte);
  endproperty
  a_ready_set: assert property (p_ready_set) else $error("byte ready not set");

  property p_overrun;
    @(posedge core_clk) disable iff (rst) byteDone && st.byteReady |=> st.overrun;
  endproperty
  a_overrun: assert property (p_overrun) else $error("overrun not set");

  property p_data_ro;
    @(posedge core_clk) disable iff (rst)
      busReq.wr && !byteDone |=> st.rxByte == $past(st.rxByte);
  endproperty
  a_data_ro: assert property (p_data_ro) else $error("data register changed on write");

  property p_read_clear;
    @(posedge core_clk) disable iff (rst)
      busReq.rd && page0 && busReq.addr == lfr_pkg::ADDR_DATA_CTLD && !byteDone
      |=> !st.byteReady && busRdata == $past(st.rxByte);
  endproperty
  a_read_clear: assert property (p_read_clear) else $error("read did not clear ready");

  property p_page_gate;
    @(posedge core_clk) disable iff (rst)
      busReq.wr && page1 && busReq.addr != lfr_pkg::ADDR_CONFIG
      |=> st.idHigh == $past(st.idHigh) && st.idLow == $past(st.idLow);
  endproperty
  a_page_gate: assert property (p_page_gate) else $error("identifier written on page one");

  property p_id_reset;
    @(posedge core_clk) disable iff (rst) $fell(rst) |-> st.idHigh == 8'h00 && st.idLow == 8'h00;
  endproperty
  a_id_reset: assert property (p_id_reset) else $error("identifier not cleared");

  property p_ignore;
    @(posedge core_clk) disable iff (rst) st.rxState == lfr_pkg::RX_IGNORE |=> !$rose(st.byteReady);
  endproperty
  a_ignore: assert property (p_ignore) else $error("byte taken from ignored message");

  property p_damp_read;
    @(posedge core_clk) disable iff (rst)
      busReq.rd && page1 && busReq.addr == lfr_pkg::ADDR_DATA_CTLD
      |=> busRdata[lfr_pkg::CD_DAMP_BIT] == $past(dampSync);
  endproperty
  a_damp_read: assert property (p_damp_read) else $error("damping status misread");

  property p_release_half;
    @(posedge core_clk) disable iff (rst)
      st.sumPrev && !sumSync && st.releaseDelay[1]
      |=> azCtrl && st.relCnt == ($past(st.releaseDelay[0]) ? REL_ONE_HALF : REL_HALF);
  endproperty
  a_release_half: assert property (p_release_half) else $error("release delay wrong");

  property p_release_none;
    @(posedge core_clk) disable iff (rst)
      st.sumPrev && !sumSync && !st.releaseDelay[1] |=> !azCtrl;
  endproperty
  a_release_none: assert property (p_release_none) else $error("release not immediate");

  property p_release_count;
    @(posedge core_clk) disable iff (rst)
      st.relCnt != 12'h000 && !sumSync
      |=> st.relCnt == $past(st.relCnt) - 12'h001 && azCtrl == (st.relCnt != 12'h000);
  endproperty
  a_release_count: assert property (p_release_count) else $error("release count wrong");

  property p_trig_low;
    @(posedge core_clk) disable iff (rst)
      azRequest && $past(st.trigMode) == lfr_pkg::TRIG_LOW |-> !$past(dataSync);
  endproperty
  a_trig_low: assert property (p_trig_low) else $error("auto-zero started with data high");

  property p_on_mode;
    @(posedge core_clk) disable iff (rst) rxError |=> (sniffReturn != onTimeEnd) &&
      (sniffReturn == $past(st.on_time_error_mode));
  endproperty
  a_on_mode: assert property (p_on_mode) else $error("error response wrong");

  property p_ack;
    @(posedge core_clk) disable iff (rst)
      busReq.wr && page0 && busReq.addr == lfr_pkg::ADDR_STATUS &&
      busReq.wdata[lfr_pkg::ST_ACK_BIT] && !byteDone |=> !st.byteReady && !st.overrun;
  endproperty
  a_ack: assert property (p_ack) else $error("acknowledge did not clear flags");

  property p_irq;
    @(posedge core_clk) disable iff (rst) st.byteReady && st.irqEnable |=> irq;
  endproperty
  a_irq: assert property (p_irq) else $error("interrupt missing");

  c_byte: cover property (@(posedge core_clk) disable iff (rst) $rose(st.byteReady));
  c_overrun: cover property (@(posedge core_clk) disable iff (rst) $rose(st.overrun));
  c_wake: cover property (@(posedge core_clk) disable iff (rst) wakeMcu);
  c_az: cover property (@(posedge core_clk) disable iff (rst) azRequest);

endmodule : lfr_regs

// >>> core/lfr_sync.sv
// two-flop synchroniser for the analog status levels
// assumes levels that change slowly against the core clock
module lfr_sync
(
  // clock and reset
  input wire logic core_clk,
  input wire logic rst,
  // levels
  input wire logic [lfr_pkg::SYNC_W-1:0] asyncIn,
  output logic [lfr_pkg::SYNC_W-1:0] syncOut
);

  lfr_pkg::lfr_sync_t st;
  lfr_pkg::lfr_sync_t next_st;

  always_comb
  begin
    next_st.stage1 = asyncIn;
    next_st.stage2 = st.stage1;
  end

  always_ff @(posedge core_clk)
  begin
    if (rst)
    begin
      st <= '0;
    end
    else
    begin
      st <= next_st;
    end
  end

  assign syncOut = st.stage2;

endmodule : lfr_sync

// >>> sim/lfr_regs_tb_top.sv
// self-checking bench for the lf receiver register slice
// assumes the register port answers reads one cycle later
`define CHK(a, b) begin nChecks++; if ((a) !== (b)) begin miscompares++; \
  $display("Error %0t: got %h exp %h", $time, a, b); end end
module lfr_regs_tb_top;
  timeunit 1ns;
  timeprecision 1ps;

  logic core_clk, rst, rxError, dampingActive, demodData, sumAzEn, azRequest;
  logic msgActive, rxBitValid, rxBit, trimShift, azCtrl, irq, wakeMcu, onTimeEnd, sniffReturn;
  lfr_pkg::lfr_bus_req_t busReq;
  logic [7:0] busRdata;
  logic [1:0] azSequence, carrierMethod;
  int miscompares = 0, nChecks = 0, wakeCnt = 0, endCnt = 0, sniffCnt = 0, azCnt = 0;
  int d[4];

  lfr_tx_model TX (.core_clk(core_clk), .msgActive(msgActive), .rxBitValid(rxBitValid),
    .rxBit(rxBit));
  lfr_regs #(.REL_HALF_CYC(4)) DUT (.core_clk(core_clk), .rst(rst), .busReq(busReq),
    .busRdata(busRdata), .msgActive(msgActive), .rxBitValid(rxBitValid), .rxBit(rxBit),
    .rxError(rxError), .dampingActive(dampingActive), .demodData(demodData),
    .sumAzEn(sumAzEn), .azSequence(azSequence), .trimShift(trimShift), .azCtrl(azCtrl),
    .azRequest(azRequest), .carrierMethod(carrierMethod), .irq(irq), .wakeMcu(wakeMcu),
    .onTimeEnd(onTimeEnd), .sniffReturn(sniffReturn));

  // ****************
  // clock, event counters, watchdog
  // ****************
  initial
  begin
    core_clk = 1'b0;
    forever #2.5 core_clk = ~core_clk;
  end
  always @(posedge core_clk)
  begin
    if (wakeMcu === 1'b1) wakeCnt++;
    if (onTimeEnd === 1'b1) endCnt++;
    if (sniffReturn === 1'b1) sniffCnt++;
    if (azRequest === 1'b1) azCnt++;
  end
  initial
  begin
    #300000;
    miscompares++;
    conclude();
  end

  // ****************
  // register port tasks
  // ****************
  task automatic wr(input logic [2:0] a, input logic [7:0] v);
    @(posedge core_clk);
    busReq <= '{addr: a, wdata: v, wr: 1'b1, rd: 1'b0};
    @(posedge core_clk);
    busReq.wr <= 1'b0;
  endtask : wr
  task automatic rdChk(input logic [2:0] a, input logic [7:0] exp);
    @(posedge core_clk);
    busReq <= '{addr: a, wdata: 8'h00, wr: 1'b0, rd: 1'b1};
    @(posedge core_clk);
    busReq.rd <= 1'b0;
    #1 `CHK(busRdata, exp)
  endtask : rdChk
  task automatic relMeasure(input logic [1:0] dly, output int n);
    wr(lfr_pkg::ADDR_DATA_CTLD, {dly, 6'h00});
    sumAzEn <= 1'b1;
    repeat (8) @(posedge core_clk);
    #1 `CHK(azCtrl, 1'b1)
    @(posedge core_clk);
    sumAzEn <= 1'b0;
    n = 0;
    while (azCtrl !== 1'b0)
    begin
      @(posedge core_clk);
      #1 n++;
      if (n > 100)
      begin
        miscompares++;
        conclude();
      end
    end
  endtask : relMeasure
  // eight demodulated edges, four cycles apart, inside one data frame
  task automatic trigRun(input logic [1:0] mode, input int exp);
    int a0;
    wr(lfr_pkg::ADDR_DATA_CTLD, {3'h0, mode, 3'h0});
    a0 = azCnt;
    fork
      TX.sendFrame(24'h000000, 3);
      repeat (8)
      begin
        repeat (4) @(posedge core_clk);
        demodData <= ~demodData;
      end
    join
    `CHK(azCnt - a0, exp)
  endtask : trigRun
  task automatic conclude();
    $display("checks %0d miscompares %0d", nChecks, miscompares);
    if (miscompares == 0 && nChecks > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask : conclude

  // ****************
  // main sequence
  // ****************
  initial
  begin
    rst = 1'b1;
    busReq = '0;
    rxError = 1'b0;
    dampingActive = 1'b0;
    demodData = 1'b0;
    sumAzEn = 1'b0;
    repeat (16) @(posedge core_clk);
    rst <= 1'b0;
    rdChk(lfr_pkg::ADDR_IDH_CTLE, 8'h00);
    rdChk(lfr_pkg::ADDR_IDL, 8'h00);
    rdChk(lfr_pkg::ADDR_CONFIG, 8'h06);
    wr(lfr_pkg::ADDR_IDH_CTLE, 8'ha5);
    wr(lfr_pkg::ADDR_IDL, 8'h3c);
    rdChk(lfr_pkg::ADDR_IDH_CTLE, 8'ha5);
    rdChk(lfr_pkg::ADDR_IDL, 8'h3c);
    $display("registers done");
    wr(lfr_pkg::ADDR_CONFIG, 8'h46);
    TX.sendFrame(24'h5aa300, 2);
    rdChk(lfr_pkg::ADDR_STATUS, 8'h88);
    `CHK(irq, 1'b1)
    wr(lfr_pkg::ADDR_DATA_CTLD, 8'hff);
    rdChk(lfr_pkg::ADDR_DATA_CTLD, 8'ha3);
    rdChk(lfr_pkg::ADDR_STATUS, 8'h08);
    `CHK(irq, 1'b0)
    wr(lfr_pkg::ADDR_STATUS, 8'h01);
    rdChk(lfr_pkg::ADDR_STATUS, 8'h00);
    $display("data done");
    wr(lfr_pkg::ADDR_CONFIG, 8'h56);
    TX.sendFrame(24'h117700, 2);
    `CHK(wakeCnt, 0)
    rdChk(lfr_pkg::ADDR_STATUS, 8'h00);
    TX.sendFrame(24'ha57700, 2);
    `CHK(wakeCnt, 1)
    rdChk(lfr_pkg::ADDR_DATA_CTLD, 8'h77);
    $display("id done");
    wr(lfr_pkg::ADDR_CONFIG, 8'h86);
    rdChk(lfr_pkg::ADDR_IDL, 8'h00);
    rdChk(lfr_pkg::ADDR_DATA_CTLD, 8'h00);
    wr(lfr_pkg::ADDR_DATA_CTLD, 8'hdf);
    rdChk(lfr_pkg::ADDR_DATA_CTLD, 8'hdf);
    @(posedge core_clk);
    dampingActive <= 1'b1;
    repeat (2) @(posedge core_clk);
    rdChk(lfr_pkg::ADDR_DATA_CTLD, 8'hff);
    wr(lfr_pkg::ADDR_IDH_CTLE, 8'hff);
    rdChk(lfr_pkg::ADDR_IDH_CTLE, 8'h07);
    `CHK(azSequence, 2'h3)
    `CHK(trimShift, 1'b1)
    for (int m = 0; m < 4; m++)
    begin
      wr(lfr_pkg::ADDR_DATA_CTLD, 8'(m));
      #1 `CHK(carrierMethod, 2'(m))
    end
    for (int m = 0; m < 2; m++)
    begin
      wr(lfr_pkg::ADDR_DATA_CTLD, 8'(m << lfr_pkg::CD_ON_TIME_ERROR_MODE_BIT));
      rxError <= 1'b1;
      @(posedge core_clk);
      rxError <= 1'b0;
      repeat (3) @(posedge core_clk);
    end
    `CHK(endCnt, 1)
    `CHK(sniffCnt, 1)
    for (int m = 0; m < 4; m++)
      relMeasure(2'(m), d[m]);
    `CHK(d[1], d[0])
    `CHK(d[2] - d[0], 4)
    `CHK(d[3] - d[0], 12)
    wr(lfr_pkg::ADDR_CONFIG, 8'h82);
    trigRun(lfr_pkg::TRIG_COUNT, 4);
    trigRun(lfr_pkg::TRIG_LOW, 4);
    trigRun(lfr_pkg::TRIG_HIGH, 3);
    wr(lfr_pkg::ADDR_CONFIG, 8'h06);
    rdChk(lfr_pkg::ADDR_IDH_CTLE, 8'ha5);
    $display("control done");
    conclude();
  end
endmodule : lfr_regs_tb_top

// >>> sim/lfr_tx_model.sv
// behavioural lf transmitter feeding demodulated bits to the receiver slice
// assumes it shares core_clk with the slice; bits are sent msb first
module lfr_tx_model
(
  // clock
  input wire logic core_clk,
  // demodulated link
  output logic msgActive,
  output logic rxBitValid,
  output logic rxBit
);
  timeunit 1ns;
  timeprecision 1ps;

  initial
  begin
    msgActive = 1'b0;
    rxBitValid = 1'b0;
    rxBit = 1'b0;
  end

  // ****************
  // one frame of 1 to 3 bytes, left aligned
  // ****************
  task automatic sendFrame(input logic [23:0] frame, input int nBytes);
    int i;
    @(posedge core_clk);
    msgActive <= 1'b1;
    for (i = 0; i < nBytes * 8; i++)
    begin
      @(posedge core_clk);
      rxBitValid <= 1'b1;
      rxBit <= frame[23-i];
      // outside a bit slot the line shows the inverse of the last bit
      @(posedge core_clk);
      rxBitValid <= 1'b0;
      rxBit <= ~frame[23-i];
    end
    @(posedge core_clk);
    msgActive <= 1'b0;
  endtask : sendFrame
endmodule : lfr_tx_model
